// *** verilog/prc_pkg.sv ***
// Package: register numbers, field layouts, codes for the privileged register console
package prc_pkg;
  localparam int REG_NUM_W = 32;
  localparam logic [5:0] REG_KSP = 6'h00;
  localparam logic [5:0] REG_ESP = 6'h01;
  localparam logic [5:0] REG_SSP = 6'h02;
  localparam logic [5:0] REG_USP = 6'h03;
  localparam logic [5:0] REG_ISP = 6'h04;
  localparam logic [5:0] REG_P0B = 6'h08;
  localparam logic [5:0] REG_P0L = 6'h09;
  localparam logic [5:0] REG_P1B = 6'h0a;
  localparam logic [5:0] REG_P1L = 6'h0b;
  localparam logic [5:0] REG_SYB = 6'h0c;
  localparam logic [5:0] REG_SYL = 6'h0d;
  localparam logic [5:0] REG_PBB = 6'h10;
  localparam logic [5:0] REG_CBB = 6'h11;
  localparam logic [5:0] REG_PRI = 6'h12;
  localparam logic [5:0] REG_AST = 6'h13;
  localparam logic [5:0] REG_SWREQ = 6'h14;
  localparam logic [5:0] REG_SWSUM = 6'h15;
  localparam logic [5:0] REG_ITC = 6'h18;
  localparam logic [5:0] REG_IRV = 6'h19;
  localparam logic [5:0] REG_ICN = 6'h1a;
  localparam logic [5:0] REG_CAL = 6'h1b;
  localparam logic [5:0] REG_RXC = 6'h20;
  localparam logic [5:0] REG_RXB = 6'h21;
  localparam logic [5:0] REG_TXC = 6'h22;
  localparam logic [5:0] REG_TXB = 6'h23;
  localparam logic [5:0] REG_MEN = 6'h38;
  localparam logic [5:0] REG_FLA = 6'h39;
  localparam logic [5:0] REG_FL1 = 6'h3a;
  localparam logic [5:0] REG_PMN = 6'h3d;
  localparam logic [5:0] REG_TYP = 6'h3e;
  localparam logic [5:0] REG_PRB = 6'h3f;
  localparam int REG_COUNT = 64;
  // Opcodes
  localparam logic [7:0] OP_MOVE_TO = 8'hDA;
  localparam logic [7:0] OP_MOVE_FROM = 8'hDB;
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  // Control/status field positions
  localparam int IE_BIT = 6;
  localparam int DONE_BIT = 7;
  localparam int ERR_BIT = 15;
  localparam int SEL_LSB = 8;
  localparam int SEL_W = 4;
  localparam int DATA_W = 8;
  localparam logic [31:0] RXC_RESET = 32'h0000_0000;
  localparam logic [31:0] TXC_RESET = 32'h0000_0080;
  localparam int TYPE_LSB = 24;
  localparam logic [7:0] CONSOLE_LEVEL = 8'h14;
  // Select codes
  localparam logic [3:0] SEL_TERM = 4'h0;
  localparam logic [3:0] SEL_DRV_DATA = 4'h1;
  localparam logic [3:0] SEL_FUNC_DONE = 4'h2;
  localparam logic [3:0] SEL_DRV_CMD = 4'h9;
  localparam logic [3:0] SEL_MISC = 4'hF;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_STATUS = 8'h02;
  localparam logic [7:0] CMD_WR_DEL = 8'h03;
  localparam logic [7:0] CMD_CANCEL = 8'h04;
  localparam logic [7:0] CODE_PROTO_ERR = 8'h05;
  localparam logic [7:0] MISC_SW_DONE = 8'h01;
  localparam logic [7:0] MISC_BOOT = 8'h02;
  localparam logic [7:0] MISC_CLR_WARM = 8'h03;
  localparam logic [7:0] MISC_CLR_COLD = 8'h04;
  localparam int STAT_SUMMARY_BIT = 7;
  typedef enum logic [1:0]
  {
    FLT_NONE,
    FLT_RSVD_OPERAND,
    FLT_RSVD_INSTR
  } prc_fault_type;
endpackage

// *** verilog/prc_console.sv ***
// Privileged register bank with console receive/transmit registers
// Contract
// - Nonexistent register number on either move gives reserved operand fault.
// - Either move outside kernel mode gives reserved instruction fault.
// - Move-to a read-only register gives reserved operand fault.
// - Move-from a write-only register gives reserved operand fault.
// - Either move updates N,Z from value, clears V, keeps C; faults keep flags.
// - Opcode DB reads the selected register longword into destination.
// - Processor type register is read-only constant with upper type field.
// - Receive control register clears to zero at bootstrap.
// - Each delivered datum sets the read-only receive-complete flag.
// - Receive interrupt at level 20 when enable AND complete rises.
// - Receive buffer error bit set on overrun or lost connection.
// - Reading receive buffer clears complete flag and its interrupt.
// - Select field 0 marks terminal data; nonzero layout implementation defined.
// - Transmit control register resets with only ready flag set.
// - Ready flag set whenever console transmitter is not busy.
// - Transmit interrupt at level 20 when enable AND ready rises.
// - Writing transmit buffer sends datum, clears ready and its interrupt.
// - Destination select 0 is terminal; value one routes to floppy.
// - Select codes: 0 terminal, 1 drive data, 2 complete, 9 command, F misc.
// - Drive commands 0..4 and misc codes 1..4 as encoded.
// - Console returns code 5 on overlapping command or unexpected data.
// - Completion status byte tagged with select code 2.
// - Status byte mirrors floppy status; bit 7 is error summary.
// - Opcode DA writes source longword into the selected register.
`timescale 1ns/1ps
module prc_console
  import prc_pkg::*;
#(
  parameter logic [7:0] TYPE_CODE = 8'hA5,
  parameter logic [23:0] TYPE_SPECIFIC = 24'h00_0001
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic instrValid,
  input wire logic [7:0] instrOpcode,
  input wire logic [1:0] currentPrivilegeMode,
  input wire logic [REG_NUM_W-1:0] regNumber,
  input wire logic [31:0] srcData,
  input wire logic [3:0] flagsIn,
  input wire logic rxValid,
  input wire logic [SEL_W-1:0] rxSelect,
  input wire logic [DATA_W-1:0] rxData,
  input wire logic rxLineError,
  input wire logic txBusy,
  output logic doneValid,
  output prc_fault_type fault,
  output logic [31:0] dstData,
  output logic dstWritten,
  output logic [3:0] flagsOut,
  output logic txValid,
  output logic [SEL_W-1:0] txSelect,
  output logic [DATA_W-1:0] txData,
  output logic rxIrq,
  output logic txIrq,
  output logic [7:0] irqLevel
);
  // Access class of one register number
  function automatic logic [1:0] regClass(input logic [5:0] n);
    // 0 none, 1 RW, 2 RO, 3 WO
    unique case (n)
      REG_KSP, REG_ESP, REG_SSP, REG_USP, REG_ISP,
      REG_P0B, REG_P0L, REG_P1B, REG_P1L, REG_SYB, REG_SYL,
      REG_PBB, REG_CBB, REG_PRI, REG_AST, REG_SWSUM, REG_ITC,
      REG_CAL, REG_RXC, REG_TXC, REG_MEN, REG_PMN: regClass = 2'd1;
      REG_ICN, REG_RXB, REG_TYP: regClass = 2'd2;
      REG_SWREQ, REG_IRV, REG_TXB, REG_FLA, REG_FL1, REG_PRB:
        regClass = 2'd3;
      default: regClass = 2'd0;
    endcase
  endfunction

  logic [31:0] bank_reg [REG_COUNT];
  logic [31:0] rxCtl_reg;
  logic [31:0] rxBuf_reg;
  logic [31:0] txCtl_reg;
  logic rxInt_reg;
  logic txInt_reg;
  logic rxIrq_reg;
  logic txIrq_reg;
  // Set by a buffer write until the console shows busy
  logic txPend_reg;
  logic [1:0] txBusySync_reg;
  logic [1:0] rxValidSync_reg;
  logic rxValidSeen_reg;
  logic [SEL_W-1:0] rxSelSync1_reg;
  logic [SEL_W-1:0] rxSelSync2_reg;
  logic [DATA_W-1:0] rxDataSync1_reg;
  logic [DATA_W-1:0] rxDataSync2_reg;
  logic [1:0] rxErrSync_reg;
  logic doneValid_reg;
  prc_fault_type fault_reg;
  logic [31:0] dstData_reg;
  logic dstWritten_reg;
  logic [3:0] flags_reg;
  logic txValid_reg;
  logic [SEL_W-1:0] txSelect_reg;
  logic [DATA_W-1:0] txData_reg;

  wire [5:0] regIdx = regNumber[5:0];
  wire inRange = (regNumber[REG_NUM_W-1:6] == '0);
  wire [1:0] cls = inRange ? regClass(regIdx) : 2'd0;
  wire isWrite = instrValid && (instrOpcode == OP_MOVE_TO);
  wire isRead = instrValid && (instrOpcode == OP_MOVE_FROM);
  wire isMove = isWrite || isRead;
  wire privFault = isMove && (currentPrivilegeMode != MODE_KERNEL);
  wire noReg = (cls == 2'd0);
  wire roFault = isWrite && (cls == 2'd2);
  wire woFault = isRead && (cls == 2'd3);
  wire opFault = isMove && !privFault && (noReg || roFault || woFault);
  wire goWrite = isWrite && !privFault && !opFault;
  wire goRead = isRead && !privFault && !opFault;
  wire rxBufRead = goRead && (regIdx == REG_RXB);
  wire txBufWrite = goWrite && (regIdx == REG_TXB);
  wire rxCtlWrite = goWrite && (regIdx == REG_RXC);
  wire txCtlWrite = goWrite && (regIdx == REG_TXC);
  wire rxArrive = rxValidSync_reg[1] && !rxValidSeen_reg;
  wire txReady = !txBusySync_reg[1];

  wire [31:0] typeWord = {TYPE_CODE, TYPE_SPECIFIC};
  wire [31:0] readMux =
    (regIdx == REG_TYP) ? typeWord :
    (regIdx == REG_RXC) ? rxCtl_reg :
    (regIdx == REG_RXB) ? rxBuf_reg :
    (regIdx == REG_TXC) ? txCtl_reg : bank_reg[regIdx];

  // complete flag, set wins over read clear
  wire rxDoneNext = rxArrive ? 1'b1 : (rxBufRead ? 1'b0 : rxCtl_reg[DONE_BIT]);
  wire rxIeNext = rxCtlWrite ? srcData[IE_BIT] : rxCtl_reg[IE_BIT];
  // ready follows transmitter, cleared on buffer write
  wire txRdyNext = txBufWrite ? 1'b0 : (txReady && !txPend_reg);
  wire txPendNext = txBufWrite ? 1'b1 :
    (txBusySync_reg[1] ? 1'b0 : txPend_reg);
  wire txIeNext = txCtlWrite ? srcData[IE_BIT] : txCtl_reg[IE_BIT];
  wire rxAnd = rxIeNext && rxDoneNext;
  wire txAnd = txIeNext && txRdyNext;
  // rising edge of enable AND complete
  wire rxIrqNext = (rxAnd && !(rxCtl_reg[IE_BIT] && rxCtl_reg[DONE_BIT]))
    ? 1'b1 : (rxBufRead || !rxAnd) ? 1'b0 : rxIrq_reg;
  // rising edge of enable AND ready
  wire txIrqNext = (txAnd && !(txCtl_reg[IE_BIT] && txCtl_reg[DONE_BIT]))
    ? 1'b1 : (txBufWrite || !txAnd) ? 1'b0 : txIrq_reg;

  // condition codes: N,Z,V,C at bits 3..0
  wire [3:0] flagsNext = (goRead || goWrite)
    ? {(goRead ? readMux[31] : srcData[31]),
       ((goRead ? readMux : srcData) == 32'h0000_0000), 1'b0, flagsIn[0]}
    : flagsIn;

  // error on line error or overrun
  wire rxErrNext = rxErrSync_reg[1] || rxCtl_reg[DONE_BIT];
  // select tag and data as delivered by console
  wire [31:0] rxWord = {16'h0000, rxErrNext, 3'b000, rxSelSync2_reg,
                        rxDataSync2_reg};

  // Synchronisers for pin-side console inputs
  always_ff @(posedge sys_clk)
  begin
    txBusySync_reg <= {txBusySync_reg[0], txBusy};
    rxValidSync_reg <= {rxValidSync_reg[0], rxValid};
    rxErrSync_reg <= {rxErrSync_reg[0], rxLineError};
    rxSelSync1_reg <= rxSelect;
    rxSelSync2_reg <= rxSelSync1_reg;
    rxDataSync1_reg <= rxData;
    rxDataSync2_reg <= rxDataSync1_reg;
    rxValidSeen_reg <= rxValidSync_reg[1];
  end

  // General bank storage
  always_ff @(posedge sys_clk)
  begin
    if (goWrite)
    begin
      bank_reg[regIdx] <= srcData;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      rxCtl_reg <= RXC_RESET;
      txCtl_reg <= TXC_RESET;
      rxBuf_reg <= 32'h0000_0000;
      rxIrq_reg <= 1'b0;
      txIrq_reg <= 1'b0;
      txPend_reg <= 1'b0;
    end
    else
    begin
      rxCtl_reg <= 32'h0000_0000;
      rxCtl_reg[DONE_BIT] <= rxDoneNext;
      rxCtl_reg[IE_BIT] <= rxIeNext;
      txCtl_reg <= 32'h0000_0000;
      txCtl_reg[DONE_BIT] <= txRdyNext;
      txCtl_reg[IE_BIT] <= txIeNext;
      if (rxArrive)
      begin
        rxBuf_reg <= rxWord;
      end
      rxIrq_reg <= rxIrqNext;
      txIrq_reg <= txIrqNext;
      txPend_reg <= txPendNext;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      doneValid_reg <= 1'b0;
      fault_reg <= FLT_NONE;
      dstData_reg <= 32'h0000_0000;
      dstWritten_reg <= 1'b0;
      flags_reg <= 4'h0;
      txValid_reg <= 1'b0;
      txSelect_reg <= SEL_TERM;
      txData_reg <= '0;
    end
    else
    begin
      doneValid_reg <= isMove;
      fault_reg <= privFault ? FLT_RSVD_INSTR :
                   opFault ? FLT_RSVD_OPERAND : FLT_NONE;
      dstWritten_reg <= goRead;
      if (goRead)
      begin
        dstData_reg <= readMux;
      end
      flags_reg <= flagsNext;
      // send datum with its select to console
      txValid_reg <= txBufWrite;
      if (txBufWrite)
      begin
        txSelect_reg <= srcData[SEL_LSB +: SEL_W];
        txData_reg <= srcData[DATA_W-1:0];
      end
    end
  end

  assign doneValid = doneValid_reg;
  assign fault = fault_reg;
  assign dstData = dstData_reg;
  assign dstWritten = dstWritten_reg;
  assign flagsOut = flags_reg;
  assign txValid = txValid_reg;
  assign txSelect = txSelect_reg;
  assign txData = txData_reg;
  assign rxIrq = rxIrq_reg;
  assign txIrq = txIrq_reg;
  assign irqLevel = CONSOLE_LEVEL;
endmodule

// *** tb/prc_console_assertions.sv ***
// Port assertions for the privileged register console
`timescale 1ns/1ps
module prc_console_chk
  import prc_pkg::*;
#(
  parameter logic [7:0] TYPE_CODE = 8'hA5
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic instrValid,
  input wire logic [7:0] instrOpcode,
  input wire logic [1:0] currentPrivilegeMode,
  input wire logic [REG_NUM_W-1:0] regNumber,
  input wire logic [31:0] srcData,
  input wire logic [3:0] flagsIn,
  input wire logic doneValid,
  input wire prc_fault_type fault,
  input wire logic [31:0] dstData,
  input wire logic dstWritten,
  input wire logic [3:0] flagsOut,
  input wire logic txValid,
  input wire logic [DATA_W-1:0] txData,
  input wire logic rxIrq,
  input wire logic txIrq,
  input wire logic [7:0] irqLevel
);
  wire logic move = instrValid &&
    (instrOpcode == OP_MOVE_TO || instrOpcode == OP_MOVE_FROM);
  wire logic kern = currentPrivilegeMode == MODE_KERNEL;
  wire logic isTo = move && kern && instrOpcode == OP_MOVE_TO;
  wire logic isFrom = move && kern && instrOpcode == OP_MOVE_FROM;
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  chk_move_answered: assert property (move |=> doneValid)
    else $error("move not answered");
  chk_mode_fault: assert property (move && !kern |=>
    fault == FLT_RSVD_INSTR && !dstWritten) else $error("mode fault");
  chk_missing_reg: assert property (isFrom && regNumber > 63 |=>
    fault == FLT_RSVD_OPERAND) else $error("missing register");
  chk_readonly_write: assert property (isTo && regNumber == REG_TYP |=>
    fault == FLT_RSVD_OPERAND) else $error("read-only write");
  chk_writeonly_read: assert property (isFrom && regNumber == REG_TXB |=>
    fault == FLT_RSVD_OPERAND && !dstWritten) else $error("write-only read");
  chk_read_flags: assert property (dstWritten |-> flagsOut ==
    {dstData[31], dstData == 0, 1'b0, $past(flagsIn[0])})
    else $error("read flags");
  chk_fault_keeps: assert property (doneValid && fault != FLT_NONE |->
    flagsOut == $past(flagsIn)) else $error("flags moved on fault");
  chk_type_const: assert property (isFrom && regNumber == REG_TYP |=>
    dstWritten && dstData[31:24] == TYPE_CODE) else $error("type code");
  chk_tx_send: assert property (isTo && regNumber == REG_TXB |=>
    txValid && !txIrq && txData == $past(srcData[7:0]))
    else $error("transmit send");
  chk_rx_clear: assert property (isFrom && regNumber == REG_RXB |=>
    !rxIrq) else $error("receive request kept");
  chk_irq_level: assert property (irqLevel == CONSOLE_LEVEL)
    else $error("interrupt level");
  cover property (move && !kern);
  cover property ($rose(rxIrq));
  cover property ($rose(txIrq));
endmodule
bind prc_console prc_console_chk #(.TYPE_CODE(TYPE_CODE)) i_prc_console_chk
(
  .sys_clk, .rstn, .instrValid, .instrOpcode, .currentPrivilegeMode,
  .regNumber, .srcData, .flagsIn, .doneValid, .fault, .dstData,
  .dstWritten, .flagsOut, .txValid, .txData, .rxIrq, .txIrq, .irqLevel
);

// *** tb/prc_console_partner.sv ***
// Console terminal model facing the console registers
`timescale 1ns/1ps
module prc_console_partner
  import prc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic txValid,
  input wire logic [SEL_W-1:0] txSelect,
  input wire logic [DATA_W-1:0] txData,
  output logic rxValid,
  output logic [SEL_W-1:0] rxSelect,
  output logic [DATA_W-1:0] rxData,
  output logic rxLineError,
  output logic txBusy
);
  logic [11:0] lastSent = 12'h000;
  int busyLeft = 0;
  initial
  begin
    rxValid = 1'b0;
    rxLineError = 1'b0;
    rxSelect = 4'h5;
    rxData = 8'hA5;
  end
  always @(posedge sys_clk)
  begin
    if (txValid)
    begin
      lastSent <= {txSelect, txData};
      busyLeft <= 6;
    end
    else if (busyLeft > 0)
      busyLeft <= busyLeft - 1;
  end
  assign txBusy = txValid || busyLeft > 0;
  task automatic send(input logic [3:0] sel, input logic [7:0] dat,
                      input logic err);
    @(posedge sys_clk);
    #1;
    rxSelect = sel;
    rxData = dat;
    rxLineError = err;
    rxValid = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    rxValid = 1'b0;
    rxLineError = 1'b0;
    rxSelect = ~sel;
    rxData = ~dat;
  endtask
endmodule

// *** tb/test_privileged_register_console.sv ***
// Self-checking bench for the privileged register console
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      failCount++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
module test_privileged_register_console
  import prc_pkg::*;
;
  // Arbitrary identification values
  localparam logic [7:0] TYPE_VAL = 8'h3C;
  localparam logic [23:0] TYPE_REST = 24'h00_0007;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic instrValid = 1'b0;
  logic [7:0] instrOpcode = 8'h00;
  logic [1:0] currentPrivilegeMode = 2'h0;
  logic [31:0] regNumber = 32'h0000_0000;
  logic [31:0] srcData = 32'h0000_0000;
  logic [3:0] flagsIn = 4'h5;
  logic rxValid, rxLineError, txBusy, doneValid, dstWritten;
  logic txValid, rxIrq, txIrq;
  logic [3:0] rxSelect, txSelect, flagsOut;
  logic [7:0] rxData, txData, irqLevel;
  logic [31:0] dstData;
  prc_fault_type fault;
  logic [5:0] woList [6] = '{REG_SWREQ, REG_IRV, REG_TXB, REG_FLA, REG_FL1,
    REG_PRB};
  logic [11:0] txList [4] = '{12'h041, 12'h904, 12'hF02, 12'h1A5};
  int failCount = 0;
  int checks = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  prc_console #(.TYPE_CODE(TYPE_VAL), .TYPE_SPECIFIC(TYPE_REST)) i_prc_console
  (
    .sys_clk, .rstn, .instrValid, .instrOpcode, .currentPrivilegeMode,
    .regNumber, .srcData, .flagsIn, .rxValid, .rxSelect, .rxData,
    .rxLineError, .txBusy, .doneValid, .fault, .dstData, .dstWritten,
    .flagsOut, .txValid, .txSelect, .txData, .rxIrq, .txIrq, .irqLevel
  );
  prc_console_partner i_prc_console_partner
  (
    .sys_clk, .txValid, .txSelect, .txData, .rxValid, .rxSelect, .rxData,
    .rxLineError, .txBusy
  );
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic mov(input logic [7:0] op, input logic [1:0] md,
                     input logic [31:0] rn, input logic [31:0] src,
                     input prc_fault_type ef);
    @(posedge sys_clk);
    #1;
    instrValid = 1'b1;
    instrOpcode = op;
    currentPrivilegeMode = md;
    regNumber = rn;
    srcData = src;
    flagsIn = ~flagsIn;
    @(posedge sys_clk);
    #1;
    instrValid = 1'b0;
    `CHK("done", 1'b1, doneValid)
    `CHK("fault", ef, fault)
  endtask
  task automatic rd(input logic [31:0] rn, input logic [31:0] ev,
                    input prc_fault_type ef);
    mov(OP_MOVE_FROM, MODE_KERNEL, rn, 32'h0000_0000, ef);
    if (ef == FLT_NONE)
      `CHK("read data", ev, dstData)
    `CHK("flags", (ef == FLT_NONE) ? {ev[31], ev == 0, 1'b0, flagsIn[0]} :
      flagsIn, flagsOut)
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failCount++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (3) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(REG_RXC, 32'h0000_0000, FLT_NONE);
    rd(REG_TXC, TXC_RESET, FLT_NONE);
    mov(OP_MOVE_TO, MODE_KERNEL, REG_KSP, 32'h8000_0001, FLT_NONE);
    rd(REG_KSP, 32'h8000_0001, FLT_NONE);
    mov(OP_MOVE_TO, MODE_KERNEL, REG_ESP, 32'h0000_0000, FLT_NONE);
    rd(REG_ESP, 32'h0000_0000, FLT_NONE);
    rd(REG_TYP, {TYPE_VAL, TYPE_REST}, FLT_NONE);
    rd(32'h0000_0005, 32'h0000_0000, FLT_RSVD_OPERAND);
    rd(32'h0000_0040, 32'h0000_0000, FLT_RSVD_OPERAND);
    foreach (woList[i])
      rd({26'h000_0000, woList[i]}, 32'h0000_0000, FLT_RSVD_OPERAND);
    mov(OP_MOVE_TO, MODE_KERNEL, REG_TYP, 32'h1, FLT_RSVD_OPERAND);
    mov(OP_MOVE_TO, MODE_KERNEL, REG_ICN, 32'h1, FLT_RSVD_OPERAND);
    for (int m = 1; m < 4; m++)
    begin
      mov(OP_MOVE_TO, m[1:0], REG_KSP, 32'h0, FLT_RSVD_INSTR);
      mov(OP_MOVE_FROM, m[1:0], 32'h40, 32'h0, FLT_RSVD_INSTR);
    end
    i_prc_console_partner.send(SEL_TERM, 8'h41, 1'b0);
    repeat (4) @(posedge sys_clk);
    rd(REG_RXC, 32'h0000_0080, FLT_NONE);
    mov(OP_MOVE_TO, MODE_KERNEL, REG_RXC, 32'h0000_0040, FLT_NONE);
    repeat (3) @(posedge sys_clk);
    `CHK("rx irq", 1'b1, rxIrq)
    rd(REG_RXB, 32'h0000_0041, FLT_NONE);
    `CHK("rx irq off", 1'b0, rxIrq)
    rd(REG_RXC, 32'h0000_0040, FLT_NONE);
    i_prc_console_partner.send(SEL_DRV_DATA, 8'hC3, 1'b0);
    i_prc_console_partner.send(SEL_FUNC_DONE, 8'h85, 1'b0);
    repeat (4) @(posedge sys_clk);
    rd(REG_RXB, 32'h0000_8285, FLT_NONE);
    i_prc_console_partner.send(SEL_TERM, 8'h7F, 1'b1);
    repeat (4) @(posedge sys_clk);
    rd(REG_RXB, 32'h0000_807F, FLT_NONE);
    mov(OP_MOVE_TO, MODE_KERNEL, REG_TXC, 32'h0000_0040, FLT_NONE);
    repeat (3) @(posedge sys_clk);
    `CHK("tx irq", 1'b1, txIrq)
    foreach (txList[i])
    begin
      mov(OP_MOVE_TO, MODE_KERNEL, REG_TXB, {20'h0, txList[i]}, FLT_NONE);
      `CHK("tx valid", 1'b1, txValid)
      `CHK("tx irq off", 1'b0, txIrq)
      repeat (3) @(posedge sys_clk);
      `CHK("tx irq held", 1'b0, txIrq)
      repeat (13) @(posedge sys_clk);
      `CHK("tx sent", txList[i], i_prc_console_partner.lastSent)
      `CHK("tx irq back", 1'b1, txIrq)
    end
    tally_and_finish();
  end
endmodule
